// [hdtvm_params.svh]
`ifndef HDTVM_PARAMS_SVH
`define HDTVM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define HDTVM_ADDR_DELAY   8'h02
`define HDTVM_ADDR_MODE    8'h03
`define HDTVM_ADDR_TRST    8'h04
`define HDTVM_ADDR_OUT     8'h05

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define HDTVM_LUMA_LSB     0
`define HDTVM_COLOUR_LSB   3
`define HDTVM_HD_BIT       0
`define HDTVM_DAC_EN_LSB   3
`define HDTVM_TRST_BIT     0
`define HDTVM_REV_BIT      0
`define HDTVM_RGB_BIT      1
`define HDTVM_SYNCINS_BIT  2
`define HDTVM_SWAP_BIT     3

// ----------------------------------------------------------------------------
// Writable bits and reset values
// ----------------------------------------------------------------------------
`define HDTVM_WMASK_DELAY  8'h3f
`define HDTVM_WMASK_MODE   8'h39
`define HDTVM_WMASK_TRST   8'h01
`define HDTVM_WMASK_OUT    8'h0e
`define HDTVM_RST_DELAY    8'h00
`define HDTVM_RST_MODE     8'h38
`define HDTVM_RST_TRST     8'h00
`define HDTVM_RST_OUT      8'h00

// ----------------------------------------------------------------------------
// Datapath constants
// ----------------------------------------------------------------------------
`define HDTVM_MAX_DELAY    3'h4
`define HDTVM_SYNC_LEVEL   10'h040

`endif

// [hdtvm_pkg.sv]
package hdtvm_pkg;
  typedef logic [7:0] hdtvm_byte_t;
  typedef logic [9:0] hdtvm_px_t;
  typedef logic [2:0] hdtvm_dsel_t;
endpackage

// [hdtvm_dly_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface hdtvm_dly_if #(
  parameter int W = 10
);
  import hdtvm_pkg::*;
  logic [W-1:0] din;
  hdtvm_dsel_t  sel;
  logic [W-1:0] dout;
  modport src (output din, output sel, input dout);
  modport dly (input din, input sel, output dout);
endinterface
`default_nettype wire

// [hdtvm_delay.sv]
`timescale 1ns/1ns
`include "hdtvm_params.svh"
`default_nettype none
module hdtvm_delay #(
  parameter int W     = 10,
  parameter int DEPTH = 4
) (
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  hdtvm_dly_if.dly   dl
);
  import hdtvm_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] tap;
  } hdtvm_dst_t;

  hdtvm_dst_t  st;
  hdtvm_dst_t  next_st;
  hdtvm_dsel_t eff_sel;

  always_comb begin
    next_st = st;
    next_st.tap[0] = dl.din;
    for (int k = 1; k < DEPTH; k++) begin
      next_st.tap[k] = st.tap[k-1];
    end
  end

  // RULE13: clamp undefined codes
  assign eff_sel = (dl.sel > `HDTVM_MAX_DELAY) ? `HDTVM_MAX_DELAY : dl.sel;

  // RULE1: tap select by code
  assign dl.dout = (eff_sel == 3'h0) ? dl.din : st.tap[eff_sel - 3'h1];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // hdtvm_delay
`default_nettype wire

// [hdtvm_ctrl.sv]
// What this block does
// RULE1: Luma output lags input by the luma delay code, 0 to 4 clocks.
// RULE2: Both colour paths and their sync lag by the colour delay code.
// RULE3: Host writes zero to reserved bits; they are not stored anyway.
// RULE4: Mode bit one selects HD mode, zero progressive scan mode.
// RULE5: Each converter enable bit powers its converter up, clear powers it down.
// RULE6: Timing reset bit written high then low clears horizontal and vertical counters.
// RULE7: Lowest output control bit reads the fixed revision code, writes ignored.
// RULE8: RGB select passes unsigned red, green, blue samples straight through.
// RULE9: Sync insert bit forces sync level onto both colour outputs during sync.
// RULE10: Sync insert has no effect in RGB input mode.
// RULE11: Swap bit exchanges red and blue difference converter assignments.
// RULE12: 4:4:4 maps both colour ports; 4:2:2 drives only the third converter (code still puts sync level on the second when sync insert is on).
// RULE13: Delay codes above four behave as four clocks.
`timescale 1ns/1ns
`include "hdtvm_params.svh"
`default_nettype none
module hdtvm_ctrl #(
  parameter int         CW       = 12,
  parameter logic       REVISION = 1'b0  // Arbitrary value
) (
  input  wire logic               I_CLK,
  input  wire logic               I_RST,
  input  wire hdtvm_pkg::hdtvm_byte_t I_REG_ADDR,
  input  wire hdtvm_pkg::hdtvm_byte_t I_REG_WDATA,
  input  wire logic               I_REG_WE,
  input  wire logic               I_REG_RE,
  output var  hdtvm_pkg::hdtvm_byte_t O_REG_RDATA,
  input  wire hdtvm_pkg::hdtvm_px_t   I_Y,
  input  wire hdtvm_pkg::hdtvm_px_t   I_CR,
  input  wire hdtvm_pkg::hdtvm_px_t   I_CBCR,
  input  wire logic               I_HSYNC_N,
  input  wire logic               I_VSYNC_N,
  input  wire logic               I_FMT_444,
  output var  hdtvm_pkg::hdtvm_px_t   O_DAC_A,
  output var  hdtvm_pkg::hdtvm_px_t   O_DAC_B,
  output var  hdtvm_pkg::hdtvm_px_t   O_DAC_C,
  output logic [2:0]              O_DAC_PD,
  output logic                    O_HD_MODE,
  output logic                    O_RGB_MODE,
  output logic                    O_TIMING_RST,
  output logic [CW-1:0]           O_HCOUNT,
  output logic [CW-1:0]           O_VCOUNT
);
  import hdtvm_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    hdtvm_byte_t r_dly;
    hdtvm_byte_t r_mode;
    hdtvm_byte_t r_trst;
    hdtvm_byte_t r_out;
    hdtvm_byte_t rdata;
    logic        hs_d;
    logic        vs_d;
    logic        trst_pulse;
    logic [CW-1:0] hcnt;
    logic [CW-1:0] vcnt;
    hdtvm_px_t   dac_a;
    hdtvm_px_t   dac_b;
    hdtvm_px_t   dac_c;
    logic [2:0]  pd;
  } hdtvm_st_t;

  hdtvm_st_t st;
  hdtvm_st_t next_st;
  // A literal cannot be part-selected, so the reset byte gets a name
  localparam hdtvm_byte_t rst_mode = `HDTVM_RST_MODE;

  // --------------------------------------------------------------------------
  // Delay lines
  // --------------------------------------------------------------------------
  hdtvm_dly_if #(.W(10)) luma_if ();
  hdtvm_dly_if #(.W(21)) col_if ();

  assign luma_if.din = I_Y;
  assign luma_if.sel = st.r_dly[`HDTVM_LUMA_LSB +: 3];
  // RULE2: sync rides with colour
  assign col_if.din  = {I_HSYNC_N, I_CR, I_CBCR};
  assign col_if.sel  = st.r_dly[`HDTVM_COLOUR_LSB +: 3];

  hdtvm_delay #(.W(10), .DEPTH(4)) u_luma_dly (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .dl    (luma_if)
  );

  hdtvm_delay #(.W(21), .DEPTH(4)) u_col_dly (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .dl    (col_if)
  );

  logic      col_sync_n;
  hdtvm_px_t col_cr;
  hdtvm_px_t col_cbcr;
  assign {col_sync_n, col_cr, col_cbcr} = col_if.dout;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic      hs_fall;
    logic      vs_fall;
    logic      swap;
    logic      sync_on;
    hdtvm_px_t b_val;
    hdtvm_px_t c_val;
    hs_fall = 1'b0;
    vs_fall = 1'b0;
    swap    = 1'b0;
    sync_on = 1'b0;
    b_val   = '0;
    c_val   = '0;
    next_st = st;

    // RULE3: reserved bits masked off
    if (I_REG_WE) begin
      case (I_REG_ADDR)
        `HDTVM_ADDR_DELAY: next_st.r_dly  = I_REG_WDATA & `HDTVM_WMASK_DELAY;
        `HDTVM_ADDR_MODE:  next_st.r_mode = I_REG_WDATA & `HDTVM_WMASK_MODE;
        `HDTVM_ADDR_TRST:  next_st.r_trst = I_REG_WDATA & `HDTVM_WMASK_TRST;
        // RULE7: revision bit not writable
        `HDTVM_ADDR_OUT:   next_st.r_out  = I_REG_WDATA & `HDTVM_WMASK_OUT;
        default:           next_st.r_out  = st.r_out;
      endcase
    end

    if (I_REG_RE) begin
      case (I_REG_ADDR)
        `HDTVM_ADDR_DELAY: next_st.rdata = st.r_dly;
        `HDTVM_ADDR_MODE:  next_st.rdata = st.r_mode;
        `HDTVM_ADDR_TRST:  next_st.rdata = st.r_trst;
        // RULE7: revision code on read
        `HDTVM_ADDR_OUT:   next_st.rdata = {st.r_out[7:1], REVISION};
        default:           next_st.rdata = 8'h00;
      endcase
    end

    // RULE6: high-then-low pulse
    next_st.trst_pulse = st.r_trst[`HDTVM_TRST_BIT] & ~next_st.r_trst[`HDTVM_TRST_BIT];

    hs_fall      = st.hs_d & ~I_HSYNC_N;
    vs_fall      = st.vs_d & ~I_VSYNC_N;
    next_st.hs_d = I_HSYNC_N;
    next_st.vs_d = I_VSYNC_N;

    // RULE6: counters cleared
    if (st.trst_pulse) begin
      next_st.hcnt = '0;
      next_st.vcnt = '0;
    end else begin
      next_st.hcnt = hs_fall ? '0 : st.hcnt + 1'b1;
      if (vs_fall) begin
        next_st.vcnt = '0;
      end else if (hs_fall) begin
        next_st.vcnt = st.vcnt + 1'b1;
      end
    end

    swap = st.r_out[`HDTVM_SWAP_BIT];
    // RULE12: port to converter map
    if (I_FMT_444) begin
      // RULE11: swap exchanges outputs
      b_val = swap ? col_cbcr : col_cr;
      c_val = swap ? col_cr : col_cbcr;
    end else begin
      b_val = '0;
      c_val = col_cbcr;
    end

    // RULE9: sync insert on colour
    // RULE10: blocked in RGB mode
    // RULE8: RGB samples pass untouched
    sync_on = st.r_out[`HDTVM_SYNCINS_BIT] & ~st.r_out[`HDTVM_RGB_BIT] & ~col_sync_n;
    if (sync_on) begin
      b_val = `HDTVM_SYNC_LEVEL;
      c_val = `HDTVM_SYNC_LEVEL;
    end

    // RULE5: converter enables
    next_st.pd    = ~st.r_mode[`HDTVM_DAC_EN_LSB +: 3];
    // Powered-down converters idle at zero to save toggling
    next_st.dac_a = st.r_mode[`HDTVM_DAC_EN_LSB]     ? luma_if.dout : '0;
    next_st.dac_b = st.r_mode[`HDTVM_DAC_EN_LSB + 1] ? b_val : '0;
    next_st.dac_c = st.r_mode[`HDTVM_DAC_EN_LSB + 2] ? c_val : '0;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st        <= '0;
      st.r_dly  <= `HDTVM_RST_DELAY;
      st.r_mode <= `HDTVM_RST_MODE;
      st.r_trst <= `HDTVM_RST_TRST;
      st.r_out  <= `HDTVM_RST_OUT;
      st.hs_d   <= 1'b1;
      st.vs_d   <= 1'b1;
      st.pd     <= ~rst_mode[`HDTVM_DAC_EN_LSB +: 3];
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign O_REG_RDATA  = st.rdata;
  assign O_DAC_A      = st.dac_a;
  assign O_DAC_B      = st.dac_b;
  assign O_DAC_C      = st.dac_c;
  assign O_DAC_PD     = st.pd;
  // RULE4: HD or progressive mode
  assign O_HD_MODE    = st.r_mode[`HDTVM_HD_BIT];
  assign O_RGB_MODE   = st.r_out[`HDTVM_RGB_BIT];
  assign O_TIMING_RST = st.trst_pulse;
  assign O_HCOUNT     = st.hcnt;
  assign O_VCOUNT     = st.vcnt;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  sequence s_trst_low_write;
    I_REG_WE && I_REG_ADDR == `HDTVM_ADDR_TRST && !I_REG_WDATA[0] && st.r_trst[0];
  endsequence
  sequence s_counters_clear;
    O_TIMING_RST ##1 (O_HCOUNT == '0 && O_VCOUNT == '0);
  endsequence

  a_luma_delay_zero: assert property ( // RULE1
    (st.r_dly[2:0] == 3'h0 && st.r_mode[3]) |=> O_DAC_A == $past(I_Y))
    else $error("luma delay 0 wrong");
  a_luma_delay_clamp: assert property ( // RULE13
    (st.r_dly[2:0] == 3'h7 && st.r_mode[3]) |=> O_DAC_A == $past(I_Y, 5))
    else $error("luma delay clamp wrong");
  a_colour_delay_four: assert property ( // RULE2
    (st.r_dly[5:3] == 3'h4 && I_FMT_444 && st.r_out[3:2] == 2'b00 && st.r_mode[4])
      |=> O_DAC_B == $past(I_CR, 5))
    else $error("colour delay 4 wrong");
  a_hd_mode_follow: assert property ( // RULE4
    (I_REG_WE && I_REG_ADDR == `HDTVM_ADDR_MODE) |=> O_HD_MODE == $past(I_REG_WDATA[0]))
    else $error("hd mode not taken");
  a_dac_power_ctl: assert property ( // RULE5
    (I_REG_WE && I_REG_ADDR == `HDTVM_ADDR_MODE) |=> ##1 O_DAC_PD == ~$past(I_REG_WDATA[5:3], 2))
    else $error("converter power wrong");
  a_timing_reset_seq: assert property ( // RULE6
    s_trst_low_write |=> s_counters_clear)
    else $error("timing reset not applied");
  a_revision_read: assert property ( // RULE7
    (I_REG_RE && I_REG_ADDR == `HDTVM_ADDR_OUT) |=> O_REG_RDATA[0] == REVISION)
    else $error("revision bit wrong");
  a_swap_map: assert property ( // RULE11
    (st.r_dly[5:3] == 3'h0 && I_FMT_444 && st.r_out[3:2] == 2'b10 && st.r_mode[4])
      |=> O_DAC_B == $past(I_CBCR))
    else $error("swap map wrong");
  a_half_rate_map: assert property ( // RULE12
    (st.r_dly[5:3] == 3'h0 && !I_FMT_444 && st.r_out[2] == 1'b0 && st.r_mode[5])
      |=> (O_DAC_B == '0 && O_DAC_C == $past(I_CBCR)))
    else $error("4:2:2 map wrong");
  a_sync_insert_on: assert property ( // RULE9
    (st.r_dly[5:3] == 3'h0 && st.r_out[2:1] == 2'b10 && !I_HSYNC_N && st.r_mode[5])
      |=> O_DAC_C == `HDTVM_SYNC_LEVEL)
    else $error("sync not inserted");
  a_sync_rgb_block: assert property ( // RULE10
    (st.r_dly[5:3] == 3'h0 && I_FMT_444 && st.r_out[3:1] == 3'b011 && st.r_mode[5])
      |=> O_DAC_C == $past(I_CBCR))
    else $error("sync inserted in rgb mode");
endmodule // hdtvm_ctrl
`default_nettype wire

// [hdtvm_host.sv]
`timescale 1ns/1ns
`default_nettype none
module hdtvm_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output var  logic [7:0] o_addr,
  output var  logic [7:0] o_wdata,
  output var  logic       o_we,
  output var  logic       o_re
);
  // ----------------------------------------
  // Host side of the register port
  // ----------------------------------------
  function automatic logic [7:0] keep(input logic [7:0] a);
    case (a)
      8'h02:   keep = 8'h3f;
      8'h03:   keep = 8'h39;
      8'h04:   keep = 8'h01;
      8'h05:   keep = 8'h0f;
      default: keep = 8'hff;
    endcase
  endfunction

  initial begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_we    = 1'b0;
    o_re    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = d & keep(a);
    o_we    = 1'b1;
    @(negedge i_clk);
    o_we    = 1'b0;
    o_wdata = ~o_wdata;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_re   = 1'b1;
    @(negedge i_clk);
    o_re   = 1'b0;
    @(posedge i_clk);
    #1;
    d = i_rdata;
  endtask

  task automatic trst();
    wr(8'h04, 8'h01);
    wr(8'h04, 8'h00);
  endtask
endmodule // hdtvm_host
`default_nettype wire

// [hdtvm_ctrl_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module hdtvm_ctrl_tb;
  import hdtvm_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} hdtvm_row_t;
  logic clk, rst, we, re, hs, vs, fmt;
  logic [7:0] addr, wd, rdv;
  hdtvm_byte_t rdata;
  hdtvm_px_t y, da, db, dc;
  logic [2:0] pd;
  logic hd, rgb, tr;
  logic [11:0] hc, vc;
  int error_cnt, comparisons, k;
  hdtvm_row_t rows [8] = '{'{8'h02, 8'h2c, 8'h2c}, '{8'h03, 8'h01, 8'h01}, '{8'h04, 8'h01, 8'h01},
    '{8'h05, 8'h0f, 8'h0e}, '{8'h06, 8'h55, 8'h00}, '{8'h03, 8'h38, 8'h38}, '{8'h04, 8'h00, 8'h00},
    '{8'h05, 8'h00, 8'h00}};

  hdtvm_host host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wd), .o_we(we), .o_re(re));
  hdtvm_ctrl dut (.I_CLK(clk), .I_RST(rst), .I_REG_ADDR(addr), .I_REG_WDATA(wd), .I_REG_WE(we),
    .I_REG_RE(re), .O_REG_RDATA(rdata), .I_Y(y), .I_CR(y + 10'h100), .I_CBCR(y + 10'h200),
    .I_HSYNC_N(hs), .I_VSYNC_N(vs), .I_FMT_444(fmt), .O_DAC_A(da), .O_DAC_B(db), .O_DAC_C(dc),
    .O_DAC_PD(pd), .O_HD_MODE(hd), .O_RGB_MODE(rgb), .O_TIMING_RST(tr), .O_HCOUNT(hc), .O_VCOUNT(vc));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Ramp on all three pixel ports makes any lag visible
  always @(negedge clk) y <= y + 10'h001;

  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic hdtvm_px_t lag(input hdtvm_px_t v, input int c);
    return v - hdtvm_px_t'((c > 4) ? 4 : c);
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end

  initial begin
    rst = 1'b1; y = '0; hs = 1'b1; fmt = 1'b1;
    vs = 1'b1;
    error_cnt = 0; comparisons = 0;
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    chk(pd, 3'h0);
    foreach (rows[i]) begin
      host.rd(rows[i].a, rdv);
      chk(rdv, (rows[i].a == 8'h03) ? 8'h38 : 8'h00);
    end
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, rdv);
      chk(rdv, rows[i].e);
    end
    $display("test registers done");
    for (k = 0; k < 8; k++) begin
      host.wr(8'h02, {2'h0, 3'(7 - k), 3'(k)});
      cyc(8);
      chk(da, lag(y, k));
      chk(db, lag(y + 10'h100, 7 - k));
    end
    $display("test delays done");
    host.wr(8'h02, 8'h00);
    host.wr(8'h05, 8'h08);
    cyc(4);
    chk(db, y + 10'h200);
    chk(dc, y + 10'h100);
    @(negedge clk) fmt = 1'b0;
    cyc(4);
    chk(db, 10'h000);
    chk(dc, y + 10'h200);
    @(negedge clk) fmt = 1'b1;
    host.wr(8'h05, 8'h04);
    @(negedge clk) hs = 1'b0;
    cyc(4);
    chk(db, 10'h040);
    chk(dc, 10'h040);
    host.wr(8'h05, 8'h06);
    cyc(4);
    chk(db, y + 10'h100);
    chk(rgb, 1'b1);
    @(negedge clk) hs = 1'b1;
    host.wr(8'h05, 8'h00);
    $display("test mapping done");
    host.wr(8'h03, 8'h30);
    cyc(4);
    chk(pd, 3'h1);
    chk(da, 10'h000);
    host.wr(8'h03, 8'h01);
    cyc(4);
    chk(hd, 1'b1);
    chk(pd, 3'h7);
    host.wr(8'h03, 8'h38);
    cyc(4);
    chk(hd, 1'b0);
    host.trst();
    k = 0;
    while (tr !== 1'b1 && k < 4) begin
      cyc(1);
      k++;
    end
    chk(tr, 1'b1);
    cyc(1);
    chk(tr, 1'b0);
    chk(hc, 12'h000);
    chk(vc, 12'h000);
    @(negedge clk) hs = 1'b0;
    cyc(1);
    chk(vc, 12'h001);
    @(negedge clk) vs = 1'b0;
    cyc(1);
    chk(vc, 12'h000);
    $display("test timing reset done");
    host.wr(8'h03, 8'h01);
    host.wr(8'h02, 8'h2c);
    @(negedge clk);
    rst = 1'b1;
    hs  = 1'b1;
    vs  = 1'b1;
    @(negedge clk) rst = 1'b0;
    chk(hd, 1'b0);
    chk(pd, 3'h0);
    chk(hc, 12'h000);
    host.rd(8'h02, rdv);
    chk(rdv, 8'h00);
    host.rd(8'h03, rdv);
    chk(rdv, 8'h38);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule // hdtvm_ctrl_tb
`default_nettype wire
